// >>> design/supply_supervisor_watchdog.v
// Operation
// - reset asserts whenever the supply is below threshold
// - reset released only after supply stays good one full timeout
// - reset polarity is a build option, timing identical
// - manual reset qualified after 25 us low, asserts 12 us later
// - reset held while manual input low, plus one timeout after
// - power-fail warning low when sense is below reference
// - power-fail path is independent and never touches reset
// - low-line warning low below trip, hysteresis before release
// - any watchdog input edge restarts the watchdog counter
// - processor toggles within timeout; otherwise reset asserts
// - watchdog timeout chosen from four factory values
`timescale 1ns/10ps
`include "supervisor_defines.vh"
module supply_supervisor_watchdog #(
    parameter        RESET_ACTIVE_HIGH = `RST_POL_RST,
    parameter [1:0]  WD_SEL            = `WD_SEL_RST,
    parameter [31:0] RST_TIMEOUT_CYC   = `RST_TIMEOUT_CYC,
    parameter [31:0] WD_CYC0           = `WD_CYC(`WD_T0_US),
    parameter [31:0] WD_CYC1           = `WD_CYC(`WD_T1_US),
    parameter [31:0] WD_CYC2           = `WD_CYC(`WD_T2_US),
    parameter [31:0] WD_CYC3           = `WD_CYC(`WD_T3_US),
    parameter [31:0] MR_QUAL_CYC       = `MR_QUAL_CYC,
    parameter [31:0] MR_DELAY_CYC      = `MR_DELAY_CYC
)(
    input  wire mclk_i,
    input  wire rst_i,
    input  wire supply_below_rst_i,
    input  wire supply_below_low_line_i,
    input  wire supply_above_low_line_hyst_i,
    input  wire manual_reset_n_i,
    input  wire watchdog_activity_in_i,
    input  wire power_fail_sense_below_ref_i,
    output reg  reset_o,
    output reg  power_fail_warn_n_o,
    output wire low_line_warn_n_o
);
    ////////////////////////////////////////////////////////////////////////
    // hold drives reset and runs the timeout, run watches the activity line
    localparam ST_HOLD    = 2'h0;
    localparam ST_RUN     = 2'h1;
    // watchdog option codes
    localparam WD_SHORT   = 2'h0;
    localparam WD_MEDIUM  = 2'h1;
    localparam WD_LONG    = 2'h2;
    localparam WD_LONGEST = 2'h3;

    // 32 bits hold the longest watchdog option at this clock
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [31:0] tmo_ff;
    reg  [31:0] nxt_tmo;
    reg  [31:0] wd_ff;
    reg  [31:0] nxt_wd;
    reg         wdi_ff;
    reg         nxt_wdi;
    reg         nxt_reset;
    reg         nxt_pf_warn_n;
    reg  [31:0] wd_limit;
    wire        mr_hold;
    wire        wd_edge;
    wire        force_rst;
    wire        tmo_done;
    wire        wd_expired;
    wire        reset_level;
    wire        release_level;

    ////////////////////////////////////////////////////////////////////////
    manual_reset_filter #(
        .QUAL_CYC  (MR_QUAL_CYC),
        .DELAY_CYC (MR_DELAY_CYC)
    ) u_mr (
        .mclk_i           (mclk_i),
        .rst_i            (rst_i),
        .manual_reset_n_i (manual_reset_n_i),
        .hold_o           (mr_hold)
    );

    line_hysteresis u_llo (
        .mclk_i          (mclk_i),
        .rst_i           (rst_i),
        .below_trip_i    (supply_below_low_line_i),
        .above_release_i (supply_above_low_line_hyst_i),
        .warn_n_o        (low_line_warn_n_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // the option is fixed at build time, so this folds to a constant
    always @*
    begin
        case (WD_SEL)
            WD_SHORT:
            begin
                wd_limit = WD_CYC0;
            end
            WD_MEDIUM:
            begin
                wd_limit = WD_CYC1;
            end
            WD_LONG:
            begin
                wd_limit = WD_CYC2;
            end
            default:
            begin
                wd_limit = WD_CYC3;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // a debounced manual hold counts as a cause just like a brownout
    assign wd_edge       = wdi_ff ^ watchdog_activity_in_i;
    assign force_rst     = supply_below_rst_i | mr_hold;
    assign tmo_done      = (tmo_ff >= RST_TIMEOUT_CYC - 32'h1);
    assign wd_expired    = (wd_ff >= wd_limit - 32'h1);
    assign reset_level   = RESET_ACTIVE_HIGH[0];
    assign release_level = ~RESET_ACTIVE_HIGH[0];

    always @*
    begin
        case (state_ff)
            ST_HOLD:
            begin
                if (!force_rst && tmo_done)
                begin
                    nxt_state = ST_RUN;
                end
                else
                begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_RUN:
            begin
                if (force_rst)
                begin
                    nxt_state = ST_HOLD;
                end
                else if (!wd_edge && wd_expired)
                begin
                    // an edge in the expiry cycle still counts as activity
                    nxt_state = ST_HOLD;
                end
                else
                begin
                    nxt_state = ST_RUN;
                end
            end
            default:
            begin
                nxt_state = ST_HOLD;
            end
        endcase
    end

    always @*
    begin
        case (state_ff)
            ST_HOLD:
            begin
                if (force_rst || tmo_done)
                begin
                    // a new cause restarts the full timeout
                    nxt_tmo = 32'h0;
                end
                else
                begin
                    nxt_tmo = tmo_ff + 32'h1;
                end
            end
            default:
            begin
                nxt_tmo = 32'h0;
            end
        endcase
    end

    always @*
    begin
        case (state_ff)
            ST_RUN:
            begin
                if (force_rst || wd_edge || wd_expired)
                begin
                    // expiry clears the count for the restart after the hold
                    nxt_wd = 32'h0;
                end
                else
                begin
                    nxt_wd = wd_ff + 32'h1;
                end
            end
            default:
            begin
                // the activity line is ignored while the cpu is held
                nxt_wd = 32'h0;
            end
        endcase
    end

    // the polarity option only swaps the two levels, timing is shared
    always @*
    begin
        if (nxt_state == ST_HOLD)
        begin
            nxt_reset = reset_level;
        end
        else
        begin
            nxt_reset = release_level;
        end
    end

    // sampled every cycle, hold included, so release brings no false edge
    always @*
    begin
        nxt_wdi = watchdog_activity_in_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // one register per process keeps each reset value beside its update
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            state_ff <= ST_HOLD;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            tmo_ff <= 32'h0;
        end
        else
        begin
            tmo_ff <= nxt_tmo;
        end
    end

    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            wd_ff <= 32'h0;
        end
        else
        begin
            wd_ff <= nxt_wd;
        end
    end

    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            wdi_ff <= 1'b0;
        end
        else
        begin
            wdi_ff <= nxt_wdi;
        end
    end

    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            reset_o <= reset_level;
        end
        else
        begin
            reset_o <= nxt_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // kept apart from the reset state so a sense fault cannot reset the cpu
    always @*
    begin
        nxt_pf_warn_n = ~power_fail_sense_below_ref_i;
    end

    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            power_fail_warn_n_o <= 1'b0;
        end
        else
        begin
            power_fail_warn_n_o <= nxt_pf_warn_n;
        end
    end
endmodule

// >>> shared/supervisor_defines.vh
`ifndef SUPERVISOR_DEFINES_VH
`define SUPERVISOR_DEFINES_VH
// timing in its own unit, cycles derived at 100 MHz
`define CLK_MHZ             100
`define MR_QUAL_US          25
`define MR_QUAL_CYC         (`MR_QUAL_US * `CLK_MHZ + 1)
`define MR_DELAY_US         12
`define MR_DELAY_CYC        (`MR_DELAY_US * `CLK_MHZ)
`define RST_TIMEOUT_MS      140
`define RST_TIMEOUT_CYC     (`RST_TIMEOUT_MS * 100000)
`define WD_T0_US            6200
`define WD_T1_US            102000
`define WD_T2_US            1600000
`define WD_T3_US            25600000
`define WD_CYC(us)          ((us) * `CLK_MHZ)
`define CNT_W               32
`define WD_SEL_RST          2'h1
`define RST_POL_RST         1'b0
`endif

// >>> design/manual_reset_filter.v
`timescale 1ns/10ps
`include "supervisor_defines.vh"
module manual_reset_filter #(
    parameter [31:0] QUAL_CYC  = `MR_QUAL_CYC,
    parameter [31:0] DELAY_CYC = `MR_DELAY_CYC
)(
    input  wire mclk_i,
    input  wire rst_i,
    input  wire manual_reset_n_i,
    output reg  hold_o
);
    reg [31:0] cnt_ff;
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cnt_ff <= 32'h0;
            hold_o <= 1'b0;
        end
        else if (manual_reset_n_i)
        begin
            cnt_ff <= 32'h0;
            hold_o <= 1'b0;
        end
        else if (cnt_ff < QUAL_CYC + DELAY_CYC)
        begin
            // qualify low time, then the fixed assertion delay
            cnt_ff <= cnt_ff + 32'h1;
        end
        else
        begin
            hold_o <= 1'b1;
        end
    end
endmodule

// >>> design/line_hysteresis.v
`timescale 1ns/10ps
module line_hysteresis (
    input  wire mclk_i,
    input  wire rst_i,
    input  wire below_trip_i,
    input  wire above_release_i,
    output reg  warn_n_o
);
    // trip and release levels come from two comparators so the band holds
    always @(posedge mclk_i)
    begin
        if (rst_i)
            warn_n_o <= 1'b0;
        else if (below_trip_i)
            warn_n_o <= 1'b0;
        else if (above_release_i)
            warn_n_o <= 1'b1;
    end
endmodule

// >>> sim/supervisor_props.sv
`timescale 1ns/10ps
module supervisor_props #(
    parameter ACTIVE_HIGH = 1'b0
)(
    input wire mclk_i,
    input wire rst_i,
    input wire supply_below_rst_i,
    input wire supply_below_low_line_i,
    input wire supply_above_low_line_hyst_i,
    input wire manual_reset_n_i,
    input wire watchdog_activity_in_i,
    input wire power_fail_sense_below_ref_i,
    input wire reset_o,
    input wire power_fail_warn_n_o,
    input wire low_line_warn_n_o
);
    reg       wd_ff;
    reg [7:0] quiet_ff;
    reg [7:0] good_ff;
    wire      held;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // compare with the built polarity so both variants are watched
    assign held = (reset_o == ACTIVE_HIGH[0]);
    // quiet counts only while released; saturate so it never wraps
    always @(posedge mclk_i)
    begin
        wd_ff <= watchdog_activity_in_i;
        quiet_ff <= (rst_i || held || wd_ff != watchdog_activity_in_i) ?
            8'h00 : quiet_ff + {7'h00, quiet_ff != 8'hFF};
        good_ff <= (rst_i || supply_below_rst_i || !manual_reset_n_i) ?
            8'h00 : good_ff + {7'h00, good_ff != 8'hFF};
    end
    a_brownout_assert: assert property (
        supply_below_rst_i |=> held) else $error("brownout");
    a_supply_hold: assert property (
        $fell(supply_below_rst_i) |-> ##18 held) else $error("early");
    a_good_release: assert property (
        good_ff == 8'h1A |-> !held) else $error("late release");
    a_manual_qual: assert property (
        !manual_reset_n_i [*8] ##1 !manual_reset_n_i [*6] |-> held)
        else $error("manual missed");
    a_manual_hold: assert property (
        held && !manual_reset_n_i |=> held) else $error("manual");
    a_pfail_follow: assert property (
        !$past(rst_i) |-> power_fail_warn_n_o ==
        !$past(power_fail_sense_below_ref_i)) else $error("power fail");
    a_lowline_trip: assert property (
        !$past(rst_i) && $past(supply_below_low_line_i) |->
        !low_line_warn_n_o) else $error("low line");
    a_wd_expiry: assert property (
        quiet_ff == 8'h1E |-> held) else $error("watchdog");
endmodule
bind supply_supervisor_watchdog supervisor_props #(
    .ACTIVE_HIGH(RESET_ACTIVE_HIGH)) props (.*);

// >>> sim/cpu_model.sv
`timescale 1ns/10ps
module cpu_model (
    input  wire mclk_i,
    input  wire reset_n_i,
    input  wire stall_i,
    output reg  activity_o
);
    reg [1:0] tick_ff;
    initial activity_o = 1'b0;
    initial tick_ff = 2'h0;
    // a processor held in reset runs no code, so it stays silent
    always @(posedge mclk_i)
    begin
        if (!reset_n_i || stall_i)
            tick_ff <= 2'h0;
        else if (tick_ff == 2'h2)
        begin
            tick_ff <= 2'h0;
            activity_o <= ~activity_o;
        end
        else
            tick_ff <= tick_ff + 2'h1;
    end
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_top;
    reg        mclk_i = 1'b0;
    reg        rst_i = 1'b1;
    reg  [4:0] in_ff = 5'h06;
    reg        stall_ff = 1'b0;
    reg  [2:0] exp_q[$];
    reg  [2:0] e;
    reg  [4:0] v;
    wire       wd;
    wire [2:0] outs;
    wire [2:0] outs_hi;
    integer    seed = 32'hAEB409A9;
    integer    fail_count = 0;
    integer    check_count = 0;
    integer    i;
    supply_supervisor_watchdog #(.RST_TIMEOUT_CYC(20), .WD_CYC1(30),
        .MR_QUAL_CYC(5), .MR_DELAY_CYC(3)) dut (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .supply_below_rst_i(in_ff[4]),
        .supply_below_low_line_i(in_ff[3]),
        .supply_above_low_line_hyst_i(in_ff[2]),
        .manual_reset_n_i(in_ff[1]),
        .watchdog_activity_in_i(wd),
        .power_fail_sense_below_ref_i(in_ff[0]),
        .reset_o(outs[2]),
        .power_fail_warn_n_o(outs[1]),
        .low_line_warn_n_o(outs[0])
    );
    cpu_model cpu (.mclk_i(mclk_i), .reset_n_i(outs[2]),
        .stall_i(stall_ff), .activity_o(wd));
    supply_supervisor_watchdog #(.RESET_ACTIVE_HIGH(1'b1),
        .RST_TIMEOUT_CYC(20), .WD_CYC1(30),
        .MR_QUAL_CYC(5), .MR_DELAY_CYC(3)) dut_hi (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .supply_below_rst_i(in_ff[4]),
        .supply_below_low_line_i(in_ff[3]),
        .supply_above_low_line_hyst_i(in_ff[2]),
        .manual_reset_n_i(in_ff[1]),
        .watchdog_activity_in_i(wd),
        .power_fail_sense_below_ref_i(in_ff[0]),
        .reset_o(outs_hi[2]),
        .power_fail_warn_n_o(outs_hi[1]),
        .low_line_warn_n_o(outs_hi[0])
    );
    initial forever #5 mclk_i = ~mclk_i;
    task end_of_test;
    begin
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    // inputs {supply low, line trip, line ok, manual_n, power fail}
    task step(input [4:0] d, input [2:0] x, input integer n);
    begin
        in_ff <= d;
        repeat (n) @(posedge mclk_i);
        exp_q.push_back(x);
    end
    endtask
    always @(negedge mclk_i)
    begin
        if (exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            `CHK("outs", e, outs)
            `CHK("reset_hi", ~e[2], outs_hi[2])
        end
    end
    initial
    begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        step(5'h06, 3'h7, 30);
        for (i = 0; i < 8; i = i + 1)
        begin
            v = $random(seed);
            step({4'h3, v[0]}, {1'b1, ~v[0], 1'b1}, 1);
        end
        step(5'h0A, 3'h6, 1);
        step(5'h02, 3'h6, 1);
        step(5'h06, 3'h7, 1);
        step(5'h16, 3'h3, 1);
        step(5'h06, 3'h3, 12);
        step(5'h06, 3'h7, 12);
        step(5'h04, 3'h7, 4);
        step(5'h06, 3'h7, 4);
        step(5'h04, 3'h3, 14);
        step(5'h04, 3'h3, 8);
        step(5'h06, 3'h3, 12);
        step(5'h06, 3'h7, 12);
        stall_ff <= 1'b1;
        step(5'h06, 3'h3, 34);
        stall_ff <= 1'b0;
        step(5'h06, 3'h7, 30);
        step(5'h06, 3'h7, 40);
        rst_i <= 1'b1;
        step(5'h06, 3'h0, 2);
        rst_i <= 1'b0;
        step(5'h06, 3'h3, 1);
        step(5'h06, 3'h7, 25);
        end_of_test;
    end
    initial
    begin
        #10000;
        fail_count++;
        end_of_test;
    end
endmodule
